// *** testbench/omcd_brake_model.sv ***
`timescale 1ns/100ps
module omcd_brake_model (
  input wire logic oe_i,
  input wire logic pin_i,
  output logic line_o,
  output logic brake_o
);
  // pull-up on the line: a released collector reads high, never the old value
  assign line_o = oe_i ? pin_i : 1'b1;
  // brake applied while the line is pulled low
  assign brake_o = ~line_o;
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  import omcd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  omcd_bus_s b = '0;
  omcd_sense_s s = '0;
  logic [31:0] rdata;
  logic oe, pin, ovh, nc, irq, line, brake;
  logic [31:0] q[$];
  logic rdp = 1'b0;
  int error_cnt = 0;
  int checks_done = 0;
  integer seed = 87;
  omcd_detector #(.TICK_CYCLES(4)) u_omcd_detector (
    .sys_clk_i(clk), .rst_i(rst), .bus_i(b), .rdata_o(rdata),
    .sense_i(s), .mpo_oc_o(pin), .mpo_oc_oe_o(oe),
    .shared_in_overheat_o(ovh), .output_stop_nc_o(nc), .irq_o(irq));
  omcd_brake_model u_omcd_brake_model (
    .oe_i(oe), .pin_i(pin), .line_o(line), .brake_o(brake));
  initial forever #2 clk = ~clk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task ck(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %0h got %0h", n, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // gap cycle after each strobe keeps one assignment per time step
  task wr(input logic [7:0] a, input logic [31:0] d);
    b.addr <= a;
    b.wdata <= d;
    b.wr <= 1'b1;
    cyc(1);
    b.wr <= 1'b0;
    cyc(1);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    b.addr <= a;
    b.rd <= 1'b1;
    cyc(1);
    b.rd <= 1'b0;
    cyc(1);
  endtask
  task run(input logic r, input bit hi, input int n);
    s.running <= r;
    s.current_pct <= hi ? 8'(20 + {$random(seed)} % 200)
                        : 8'({$random(seed)} % 20);
    cyc(n);
  endtask
  task pins(input logic [2:0] e);
    @(negedge clk);
    ck("oe_irq_brake", {29'h0, e}, {29'h0, oe, irq, brake});
    @(posedge clk);
  endtask
  task final_report;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // read monitor: data stands only in the cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge clk) rdp <= b.rd;
  always @(negedge clk) begin
    if (rdp)
      ck("rdata", q.pop_front(), rdata);
  end
  initial begin
    #100000;
    error_cnt++;
    final_report;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(16);
    rst <= 1'b0;
    cyc(1);
    rd(OFS_LEVEL, 32'h5);
    rd(OFS_TIME, 32'h32);
    rd(OFS_ASSIGN, 32'h0);
    rd(8'h1C, 32'h0);
    rd(OFS_STATE, 32'(S_IDLE));
    wr(OFS_LEVEL, 32'h33);
    rd(OFS_LEVEL, 32'h5);
    wr(OFS_TIME, 32'h4);
    wr(OFS_TIME, 32'h65);
    rd(OFS_TIME, 32'h32);
    wr(OFS_TIME, 32'h64);
    rd(OFS_TIME, 32'h64);
    for (int v = 0; v < 8; v++) begin
      wr(OFS_TFS, 32'(v));
      @(negedge clk);
      ck("tfs", {30'h0, v[1], v[0]}, {30'h0, nc, ovh});
      @(posedge clk);
    end
    wr(OFS_TFS, 32'h8);
    rd(OFS_TFS, 32'h7);
    // modest level with the shortest time so a weak current still trips
    wr(OFS_LEVEL, 32'h14);
    wr(OFS_TIME, 32'h5);
    wr(OFS_ASSIGN, 32'h9);
    wr(OFS_ASSIGN, 32'h109);
    rd(OFS_ASSIGN, 32'h9);
    wr(OFS_MASK, 32'h1);
    rd(OFS_MASK, 32'h1);
    run(1'b1, 1'b0, 30);
    pins(3'b111);
    run(1'b1, 1'b1, 30);
    pins(3'b111);
    cyc(20);
    pins(3'b010);
    rd(OFS_STATUS, 32'h3);
    wr(OFS_STATUS, 32'h3);
    pins(3'b000);
    run(1'b1, 1'b0, 15);
    run(1'b1, 1'b1, 2);
    run(1'b1, 1'b0, 15);
    pins(3'b000);
    run(1'b0, 1'b0, 40);
    pins(3'b000);
    rd(OFS_STATUS, 32'h0);
    wr(OFS_TFS, 32'h3);
    run(1'b1, 1'b0, 30);
    pins(3'b010);
    rd(OFS_STATUS, 32'h1);
    rd(OFS_STATE, 32'(S_DET));
    wr(OFS_TFS, 32'h4);
    wr(OFS_ASSIGN, 32'h8);
    pins(3'b010);
    wr(OFS_MASK, 32'h0);
    pins(3'b000);
    final_report;
  end
endmodule

// *** verilog/omcd_detector.sv ***
`timescale 1ns/100ps
// Behaviour
// (RQ1) running, low current too long: raise detection
// (RQ2) level 0 to 50 percent, default 5
// (RQ3) time 0.05 to 1 s, default 0.5
// (RQ4) pin drives only with assignment value 9
// (RQ5) function select 0-7 sets input roles
// (RQ6) current back above level: hold about 100ms
// (RQ7) avoid high level with long time; writes check each setting alone, level 50 with time 100 is accepted
// (RQ8) timer restarts above level, idle when stopped
module omcd_detector #(
  parameter int TICK_CYCLES = omcd_pkg::TICK_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire omcd_pkg::omcd_bus_s bus_i,
  output logic [31:0] rdata_o,
  input wire omcd_pkg::omcd_sense_s sense_i,
  output logic mpo_oc_o,
  output logic mpo_oc_oe_o,
  output logic shared_in_overheat_o,
  output logic output_stop_nc_o,
  output logic irq_o
);
  import omcd_pkg::*;

  logic [7:0] level_q;
  logic [7:0] time_q;
  logic [7:0] assign_q;
  logic [2:0] tfs_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic [1:0] status_set;
  logic [1:0] status_clr;
  omcd_state_e state_q;
  omcd_state_e state_d;
  logic [21:0] div_q;
  logic [7:0] ticks_q;
  logic tick;
  logic below;
  logic pin_en;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // out-of-range writes are dropped so a setting is always legal, except mask writes, which keep wdata[1:0] of any value
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      level_q <= LEVEL_RST; // [RQ2]
      time_q <= TIME_RST; // [RQ3]
      assign_q <= ASSIGN_RST;
      tfs_q <= TFS_RST;
      mask_q <= IRQ_RST;
    end else if (bus_i.wr) begin
      if (bus_i.addr == OFS_LEVEL && bus_i.wdata <= 32'(LEVEL_MAX)) begin
        level_q <= bus_i.wdata[7:0]; // [RQ2]
      end
      if (bus_i.addr == OFS_TIME && bus_i.wdata >= 32'(TIME_MIN) &&
          bus_i.wdata <= 32'(TIME_MAX)) begin
        time_q <= bus_i.wdata[7:0]; // [RQ3]
      end
      if (bus_i.addr == OFS_ASSIGN && bus_i.wdata[31:8] == 24'h000000) begin
        assign_q <= bus_i.wdata[7:0];
      end
      if (bus_i.addr == OFS_TFS && bus_i.wdata[31:3] == 29'h0) begin
        tfs_q <= bus_i.wdata[2:0]; // [RQ5]
      end
      if (bus_i.addr == OFS_MASK) begin
        mask_q <= bus_i.wdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else if (bus_i.rd) begin
      unique case (bus_i.addr)
        OFS_LEVEL: rdata_o <= {24'h000000, level_q};
        OFS_TIME: rdata_o <= {24'h000000, time_q};
        OFS_ASSIGN: rdata_o <= {24'h000000, assign_q};
        OFS_TFS: rdata_o <= {29'h0, tfs_q};
        OFS_STATUS: rdata_o <= {30'h0, status_q};
        OFS_MASK: rdata_o <= {30'h0, mask_q};
        OFS_STATE: rdata_o <= {20'h00000, ticks_q, state_q};
        default: rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // qualification timer
  // ----------------------------------------------------------------
  // a zero level never qualifies: current cannot fall below 0 A
  assign below = sense_i.running && (sense_i.current_pct < level_q); // [RQ1]
  assign tick = (div_q == 22'(TICK_CYCLES - 1));

  // the divider restarts with each phase, so timing is exact to a cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || state_d != state_q || state_q == S_IDLE ||
        state_q == S_DET) begin
      div_q <= 22'h0; // [RQ8]
      ticks_q <= 8'h00;
    end else if (tick) begin
      div_q <= 22'h0;
      ticks_q <= ticks_q + 8'h01;
    end else begin
      div_q <= div_q + 22'h1;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: if (below) state_d = S_QUAL;
      S_QUAL: begin
        if (!below) begin
          state_d = S_IDLE; // [RQ8]
        end else if (tick && ticks_q + 8'h01 >= time_q) begin
          state_d = S_DET; // [RQ1] [RQ3]
        end
      end
      S_DET: if (!below) state_d = S_HOLD;
      S_HOLD: begin
        if (below) begin
          state_d = S_DET;
        end else if (tick && ticks_q + 8'h01 >= HOLD_TICKS) begin
          state_d = S_IDLE; // [RQ6]
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // terminals
  // ----------------------------------------------------------------
  assign pin_en = (assign_q == ASSIGN_DET) && tfs_q[TFS_DET_BIT];

  // open collector: the pin is only ever pulled low, never driven high
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mpo_oc_o <= 1'b0;
      mpo_oc_oe_o <= 1'b0;
      shared_in_overheat_o <= 1'b0;
      output_stop_nc_o <= 1'b0;
    end else begin
      mpo_oc_o <= 1'b0;
      mpo_oc_oe_o <= pin_en && (state_q == S_DET ||
                                state_q == S_HOLD); // [RQ4] [RQ6]
      shared_in_overheat_o <= tfs_q[TFS_OVH_BIT]; // [RQ5]
      output_stop_nc_o <= tfs_q[TFS_NC_BIT]; // [RQ5]
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign status_set[ST_DET] = (state_q == S_QUAL) && (state_d == S_DET);
  assign status_set[ST_REL] = (state_q == S_HOLD) && (state_d == S_IDLE);
  assign status_clr = (bus_i.wr && bus_i.addr == OFS_STATUS) ?
                      bus_i.wdata[1:0] : 2'h0;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      status_q <= IRQ_RST;
      irq_o <= 1'b0;
    end else begin
      status_q <= status_set | (status_q & ~status_clr);
      irq_o <= |(status_q & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_qual_end;
    state_q == S_QUAL ##1 state_q == S_DET;
  endsequence

  sequence s_hold_end;
    state_q == S_HOLD ##1 state_q == S_IDLE;
  endsequence

  a_level_range: assert property (level_q <= LEVEL_MAX) // [RQ2]
    else $error("level out of range");
  a_time_range: assert property ( // [RQ3]
    time_q >= TIME_MIN && time_q <= TIME_MAX)
    else $error("time out of range");
  a_qual_elapsed: assert property (s_qual_end |-> // [RQ1]
    $past(ticks_q) + 8'h01 >= $past(time_q) && status_q[ST_DET])
    else $error("detect before time elapsed");
  a_pin_gate: assert property (mpo_oc_oe_o |-> // [RQ4]
    $past(assign_q) == ASSIGN_DET && $past(tfs_q[TFS_DET_BIT]))
    else $error("pin driven while unassigned");
  a_pin_hold: assert property ( // [RQ6]
    state_q == S_DET && !below && pin_en |=> ##1 mpo_oc_oe_o)
    else $error("pin not held after current rose");
  a_hold_span: assert property (s_hold_end |-> // [RQ6]
    $past(ticks_q) + 8'h01 >= HOLD_TICKS)
    else $error("hold released early");
  a_timer_restart: assert property ( // [RQ8]
    state_q == S_QUAL && !below |=> state_q == S_IDLE && ticks_q == 8'h00)
    else $error("timer not restarted");
  a_stopped_idle: assert property ( // [RQ8]
    !sense_i.running && state_q == S_IDLE |=> state_q == S_IDLE)
    else $error("timer started while stopped");
  a_status_sticky: assert property ( // [RQ1]
    status_q[ST_DET] && !status_clr[ST_DET] |=> status_q[ST_DET])
    else $error("status bit lost");
  a_irq_follow: assert property ( // [RQ1]
    status_q[ST_DET] && mask_q[ST_DET] ##1 status_q[ST_DET] |-> irq_o)
    else $error("irq missing");
endmodule

// *** verilog/omcd_pkg.sv ***
package omcd_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int TICK_MS = 10;
  localparam int TICK_CYC = TICK_MS * CLK_MHZ * 1000;
  localparam int HOLD_MS = 100;
  localparam logic [7:0] HOLD_TICKS = 8'(HOLD_MS / TICK_MS);
  // ----------------------------------------------------------------
  // settings, time in ticks of 10 ms
  // ----------------------------------------------------------------
  localparam logic [7:0] LEVEL_MAX = 8'h32;
  localparam logic [7:0] LEVEL_RST = 8'h05;
  localparam logic [7:0] TIME_MIN = 8'h05;
  localparam logic [7:0] TIME_MAX = 8'h64;
  localparam logic [7:0] TIME_RST = 8'h32;
  localparam logic [7:0] ASSIGN_DET = 8'h09;
  localparam logic [7:0] ASSIGN_RST = 8'h00;
  localparam logic [2:0] TFS_RST = 3'h0;
  localparam int TFS_OVH_BIT = 0;
  localparam int TFS_NC_BIT = 1;
  localparam int TFS_DET_BIT = 2;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LEVEL = 8'h00;
  localparam logic [7:0] OFS_TIME = 8'h04;
  localparam logic [7:0] OFS_ASSIGN = 8'h08;
  localparam logic [7:0] OFS_TFS = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;
  localparam int ST_DET = 0;
  localparam int ST_REL = 1;
  localparam logic [1:0] IRQ_RST = 2'h0;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } omcd_bus_s;

  typedef struct packed {
    logic running;
    logic [7:0] current_pct;
  } omcd_sense_s;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_QUAL = 4'b0010,
    S_DET = 4'b0100,
    S_HOLD = 4'b1000
  } omcd_state_e;
endpackage
